// File: fslc_pkg.sv
package fslc_pkg;

    // Control characters of the framed link
    localparam logic [7:0] CH_START = 8'h02;
    localparam logic [7:0] CH_END = 8'h03;
    localparam logic [7:0] CH_EOT = 8'h04;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_NAK = 8'h15;

    // Attempts per frame before the exchange is given up
    localparam logic [1:0] MAX_TRIES = 2'h3;

    // Reply window
    localparam int CLK_HZ = 10_000_000;
    localparam int REPLY_MS = 200;
    localparam int REPLY_CYC = REPLY_MS * (CLK_HZ / 1000);

    // Buffer sizes
    localparam int PAY_DEPTH = 32;
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W = 9;

    // One payload byte handed upward, with its end-of-frame marker
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } fslc_word_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_CHECK,
        ST_REPLY,
        ST_DELIVER,
        ST_LOAD,
        ST_SEND,
        ST_WAIT,
        ST_EOT
    } fslc_state_t;

endpackage

// File: fslc_link.sv
`timescale 1ns/1ps

module fslc_fifo #(
    parameter int WIDTH = fslc_pkg::WORD_W,
    parameter int DEPTH = fslc_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_word_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_word_o,
    input wire logic out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] count;
    } fslc_fifo_regs_t;
    fslc_fifo_regs_t st;
    fslc_fifo_regs_t next_st;
    logic push;
    logic pop;
    assign in_ready_o = (st.count != (AW+1)'(DEPTH));
    assign out_valid_o = (st.count != '0);
    assign out_word_o = st.mem[st.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_word_i;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        // A full FIFO stops the deliver path, which in turn stops the receiver
        case ({push, pop})
            2'b10: next_st.count = st.count + 1'b1;
            2'b01: next_st.count = st.count - 1'b1;
            default: next_st.count = st.count;
        endcase
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end
endmodule

module fslc_link #(
    parameter int PAY_DEPTH = fslc_pkg::PAY_DEPTH,
    parameter int FIFO_DEPTH = fslc_pkg::FIFO_DEPTH,
    parameter int REPLY_CYC = fslc_pkg::REPLY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic framed_protocol_setting_i,
    input wire logic handshake_en_i,
    input wire logic clear_to_send_i,
    input wire logic data_set_ready_i,
    input wire logic [7:0] module_addr_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] resp_byte_i,
    input wire logic resp_last_i,
    input wire logic resp_repeat_i,
    input wire logic resp_valid_i,
    output logic resp_ready_o,
    output fslc_pkg::fslc_word_t cmd_word_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic check_error_o,
    output logic tx_done_o,
    output logic tx_abort_o,
    output logic link_abort_o
);
    typedef struct packed {
        fslc_pkg::fslc_state_t state;
        logic [PAY_DEPTH-1:0][7:0] pay;
        logic [7:0] len;
        logic [7:0] pos;
        logic [7:0] block_check_byte;
        logic good;
        logic repeat_mode;
        logic [1:0] tries;
        logic [31:0] timer;
        logic rx_ready;
        logic resp_ready;
        logic tx_valid;
        logic [7:0] tx_byte;
        logic check_error;
        logic tx_done;
        logic tx_abort;
        logic link_abort;
    } fslc_regs_t;

    fslc_regs_t st;
    fslc_regs_t next_st;
    logic hs_tx_ok;
    logic hs_rx_ok;
    logic tx_taken;
    logic tx_free;
    logic rx_take;
    logic resp_take;
    logic push_valid;
    logic push_ready;
    fslc_pkg::fslc_word_t push_word;
    logic [7:0] send_byte;
    logic [7:0] end_pos;
    // Modem lines only matter with handshake on
    assign hs_tx_ok = !handshake_en_i || clear_to_send_i;
    assign hs_rx_ok = !handshake_en_i || data_set_ready_i;
    assign tx_taken = st.tx_valid && tx_ready_i;
    assign tx_free = !st.tx_valid || tx_taken;
    assign rx_take = rx_valid_i && st.rx_ready;
    assign resp_take = resp_valid_i && st.resp_ready;
    assign end_pos = st.len + 8'h03;
    assign push_valid = (st.state == fslc_pkg::ST_DELIVER) && (st.len != 8'h00);
    assign push_word.data = st.pay[st.pos];
    assign push_word.last = (st.pos == st.len - 8'h01);
    // Byte for the current position of an outgoing frame
    always_comb begin
        if (st.pos == 8'h00) begin
            send_byte = fslc_pkg::CH_START;
        end else if (st.pos == 8'h01) begin
            send_byte = module_addr_i;
        end else if (st.pos <= st.len + 8'h01) begin
            send_byte = st.pay[8'(st.pos - 8'h02)];
        end else if (st.pos == st.len + 8'h02) begin
            send_byte = fslc_pkg::CH_END;
        end else begin
            send_byte = st.block_check_byte;
        end
    end
    always_comb begin
        next_st = st;
        next_st.check_error = 1'b0;
        next_st.tx_done = 1'b0;
        next_st.tx_abort = 1'b0;
        next_st.link_abort = 1'b0;
        if (tx_taken) begin
            next_st.tx_valid = 1'b0;
        end
        case (st.state)
            fslc_pkg::ST_IDLE: begin
                if (!framed_protocol_setting_i) begin
                    // Unframed: bytes pass one at a time in both directions
                    if (resp_take) begin
                        next_st.tx_valid = 1'b1;
                        next_st.tx_byte = resp_byte_i;
                    end else if (rx_take) begin
                        next_st.pay[0] = rx_byte_i;
                        next_st.len = 8'h01;
                        next_st.pos = 8'h00;
                        next_st.state = fslc_pkg::ST_DELIVER;
                    end
                end else if (resp_take) begin
                    // A response start wins over a line byte in the same cycle
                    next_st.pay[0] = resp_byte_i;
                    next_st.len = 8'h01;
                    next_st.repeat_mode = resp_repeat_i;
                    next_st.pos = 8'h00;
                    next_st.tries = 2'h0;
                    next_st.block_check_byte = 8'h00;
                    next_st.state = resp_last_i ? fslc_pkg::ST_SEND : fslc_pkg::ST_LOAD;
                end else if (rx_take) begin
                    if (rx_byte_i == fslc_pkg::CH_START) begin
                        next_st.len = 8'h00;
                        next_st.good = 1'b1;
                        next_st.state = fslc_pkg::ST_ADDR;
                    end else if (rx_byte_i == fslc_pkg::CH_EOT) begin
                        next_st.link_abort = 1'b1;
                    end
                end
            end
            fslc_pkg::ST_ADDR: begin
                if (rx_take) begin
                    if (rx_byte_i == fslc_pkg::CH_EOT) begin
                        next_st.link_abort = 1'b1;
                        next_st.state = fslc_pkg::ST_IDLE;
                    end else begin
                        next_st.block_check_byte = rx_byte_i;
                        next_st.state = fslc_pkg::ST_DATA;
                    end
                end
            end
            fslc_pkg::ST_DATA: begin
                if (rx_take) begin
                    next_st.block_check_byte = st.block_check_byte ^ rx_byte_i;
                    if (rx_byte_i == fslc_pkg::CH_EOT) begin
                        next_st.link_abort = 1'b1;
                        next_st.state = fslc_pkg::ST_IDLE;
                    end else if (rx_byte_i == fslc_pkg::CH_END) begin
                        next_st.state = fslc_pkg::ST_CHECK;
                    end else if (st.len == 8'(PAY_DEPTH)) begin
                        // Too long to hold: refused with a negative answer
                        next_st.good = 1'b0;
                    end else begin
                        next_st.pay[st.len] = rx_byte_i;
                        next_st.len = st.len + 8'h01;
                    end
                end
            end
            fslc_pkg::ST_CHECK: begin
                // Any value is the check byte here, 04 included
                if (rx_take) begin
                    if (rx_byte_i != st.block_check_byte) begin
                        next_st.good = 1'b0;
                        next_st.check_error = 1'b1;
                    end
                    next_st.pos = 8'h00;
                    next_st.state = fslc_pkg::ST_REPLY;
                end
            end
            fslc_pkg::ST_REPLY: begin
                // Answered at once, far inside the reply window
                if (st.pos == 8'h00 && tx_free && hs_tx_ok) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_byte = st.good ? fslc_pkg::CH_ACK : fslc_pkg::CH_NAK;
                    next_st.pos = 8'h01;
                end else if (st.pos == 8'h01 && tx_taken) begin
                    next_st.pos = 8'h00;
                    next_st.state = st.good ? fslc_pkg::ST_DELIVER : fslc_pkg::ST_IDLE;
                end
            end
            fslc_pkg::ST_DELIVER: begin
                if (st.len == 8'h00) begin
                    next_st.state = fslc_pkg::ST_IDLE;
                end else if (push_ready) begin
                    next_st.pos = st.pos + 8'h01;
                    if (push_word.last) begin
                        next_st.state = fslc_pkg::ST_IDLE;
                    end
                end
            end
            fslc_pkg::ST_LOAD: begin
                if (resp_take) begin
                    next_st.pay[st.len] = resp_byte_i;
                    next_st.len = st.len + 8'h01;
                    // An over-long response is cut at the buffer size
                    if (resp_last_i || st.len == 8'(PAY_DEPTH - 1)) begin
                        next_st.state = fslc_pkg::ST_SEND;
                    end
                end
            end
            fslc_pkg::ST_SEND: begin
                if (tx_free && hs_tx_ok) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_byte = send_byte;
                    next_st.pos = st.pos + 8'h01;
                    if (st.pos != 8'h00 && st.pos != end_pos) begin
                        next_st.block_check_byte = st.block_check_byte ^ send_byte;
                    end
                    if (st.pos == end_pos) begin
                        next_st.timer = 32'h0;
                        if (st.repeat_mode) begin
                            next_st.tx_done = 1'b1;
                            next_st.state = fslc_pkg::ST_IDLE;
                        end else begin
                            next_st.state = fslc_pkg::ST_WAIT;
                        end
                    end
                end
            end
            fslc_pkg::ST_WAIT: begin
                next_st.timer = st.timer + 32'h1;
                if (rx_take && rx_byte_i == fslc_pkg::CH_ACK) begin
                    next_st.tx_done = 1'b1;
                    next_st.state = fslc_pkg::ST_IDLE;
                end else if (rx_take && rx_byte_i == fslc_pkg::CH_EOT) begin
                    next_st.link_abort = 1'b1;
                    next_st.state = fslc_pkg::ST_IDLE;
                end else if ((rx_take && rx_byte_i == fslc_pkg::CH_NAK) ||
                             st.timer == 32'(REPLY_CYC - 1)) begin
                    if (st.tries == fslc_pkg::MAX_TRIES - 2'h1) begin
                        next_st.state = fslc_pkg::ST_EOT;
                    end else begin
                        // Buffer is untouched, so the resend is identical
                        next_st.tries = st.tries + 2'h1;
                        next_st.pos = 8'h00;
                        next_st.block_check_byte = 8'h00;
                        next_st.state = fslc_pkg::ST_SEND;
                    end
                end
            end
            fslc_pkg::ST_EOT: begin
                if (tx_free && hs_tx_ok) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_byte = fslc_pkg::CH_EOT;
                    next_st.tx_abort = 1'b1;
                    next_st.state = fslc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_st.state = fslc_pkg::ST_IDLE;
            end
        endcase
        // Ready flags are registered, so they follow the next state
        next_st.rx_ready = hs_rx_ok && (next_st.state == fslc_pkg::ST_ADDR ||
            next_st.state == fslc_pkg::ST_DATA || next_st.state == fslc_pkg::ST_CHECK ||
            next_st.state == fslc_pkg::ST_WAIT || next_st.state == fslc_pkg::ST_IDLE);
        next_st.resp_ready = framed_protocol_setting_i ?
            (next_st.state == fslc_pkg::ST_IDLE || next_st.state == fslc_pkg::ST_LOAD) :
            (next_st.state == fslc_pkg::ST_IDLE && !next_st.tx_valid && hs_tx_ok);
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end
    fslc_fifo #(
        .WIDTH(fslc_pkg::WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) i_fslc_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(push_valid),
        .in_word_i(push_word),
        .in_ready_o(push_ready),
        .out_valid_o(cmd_valid_o),
        .out_word_o(cmd_word_o),
        .out_ready_i(cmd_ready_i)
    );
    assign rx_ready_o = st.rx_ready;
    assign tx_byte_o = st.tx_byte;
    assign tx_valid_o = st.tx_valid;
    assign resp_ready_o = st.resp_ready;
    assign check_error_o = st.check_error;
    assign tx_done_o = st.tx_done;
    assign tx_abort_o = st.tx_abort;
    assign link_abort_o = st.link_abort;
endmodule

// File: fslc_link_checker.sv
`timescale 1ns/1ps

module fslc_link_checker (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic framed_protocol_setting_i,
    input wire logic handshake_en_i,
    input wire logic data_set_ready_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_ready_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] resp_byte_i,
    input wire logic resp_last_i,
    input wire logic resp_valid_i,
    input wire logic resp_ready_o,
    input wire fslc_pkg::fslc_word_t cmd_word_o,
    input wire logic cmd_valid_o,
    input wire logic cmd_ready_i,
    input wire logic check_error_o,
    input wire logic tx_abort_o,
    input wire logic link_abort_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_tx_holds: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
        else $error("tx byte changed before it was taken");
    a_nak_on_error: assert property (check_error_o |-> ##[0:2] (tx_valid_o && tx_byte_o == fslc_pkg::CH_NAK))
        else $error("check mismatch not answered with negative acknowledge");
    a_eot_on_abort: assert property (tx_abort_o |-> ##[0:2] (tx_valid_o && tx_byte_o == fslc_pkg::CH_EOT))
        else $error("abort without end of transmission byte");
    a_frame_start: assert property (framed_protocol_setting_i && resp_valid_i && resp_ready_o && resp_last_i
        |-> ##[1:3] (tx_valid_o && tx_byte_o == fslc_pkg::CH_START))
        else $error("response frame did not open with start byte");
    a_raw_echo: assert property (!framed_protocol_setting_i && resp_valid_i && resp_ready_o
        |=> tx_valid_o && tx_byte_o == $past(resp_byte_i))
        else $error("raw response byte not passed through");
    a_raw_last: assert property (!framed_protocol_setting_i && cmd_valid_o |-> cmd_word_o.last)
        else $error("raw byte delivered without end marker");
    a_hs_block: assert property (handshake_en_i && !data_set_ready_i |=> !rx_ready_o)
        else $error("receive not blocked by handshake");
    a_eot_cause: assert property ($rose(link_abort_o)
        |-> ($past(rx_byte_i) == fslc_pkg::CH_EOT || $past(rx_byte_i, 2) == fslc_pkg::CH_EOT))
        else $error("link abort without received end of transmission");
    a_fifo_holds: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_word_o))
        else $error("delivered word lost while stalled");
endmodule

bind fslc_link fslc_link_checker i_fslc_link_checker (.ref_clk_i, .rst_i, .framed_protocol_setting_i,
    .handshake_en_i, .data_set_ready_i, .rx_byte_i, .rx_ready_o, .tx_byte_o, .tx_valid_o, .tx_ready_i,
    .resp_byte_i, .resp_last_i, .resp_valid_i, .resp_ready_o, .cmd_word_o, .cmd_valid_o, .cmd_ready_i,
    .check_error_o, .tx_abort_o, .link_abort_o);

// File: fslc_host_model.sv
`timescale 1ns/1ps

module fslc_host_model (
    input wire logic ref_clk_i,
    input wire logic ready_i,
    output logic [7:0] byte_o,
    output logic valid_o,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    logic [7:0] txq[$];
    logic slow = 1'b0;

    initial begin
        byte_o = 8'h00;
        valid_o = 1'b0;
        tx_ready_o = 1'b1;
    end

    // Slow mode stalls every other cycle so each device byte must wait
    always @(negedge ref_clk_i) tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    always @(posedge ref_clk_i) if (tx_valid_i && tx_ready_o) txq.push_back(tx_byte_i);

    task automatic put(input logic [7:0] b);
        @(negedge ref_clk_i);
        valid_o = 1'b1;
        byte_o = b;
        while (ready_i !== 1'b1) @(negedge ref_clk_i);
        @(posedge ref_clk_i);
    endtask

    // Released line shows the inverse so a stale byte cannot pass for a fresh one
    task automatic release_line();
        @(negedge ref_clk_i);
        valid_o = 1'b0;
        byte_o = ~byte_o;
    endtask

    task automatic reply(input logic [7:0] b);
        put(b);
        release_line();
    endtask

    task automatic send_frame(input logic [7:0] p[$], input logic [7:0] flip);
        logic [7:0] x;
        x = 8'h37 ^ fslc_pkg::CH_END;
        put(fslc_pkg::CH_START);
        put(8'h37);
        foreach (p[i]) begin
            put(p[i]);
            x ^= p[i];
        end
        put(fslc_pkg::CH_END);
        put(x ^ flip);
        release_line();
    endtask
endmodule

// File: fslc_link_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module fslc_link_tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic framed = 1'b1;
    logic hs_en = 1'b0;
    logic dsr = 1'b1;
    logic cts = 1'b1;
    logic [7:0] rx_byte, tx_byte;
    logic [7:0] resp_byte = 8'h00;
    logic resp_last = 1'b0;
    logic resp_rep = 1'b0;
    logic resp_valid = 1'b0;
    logic cmd_ready = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, resp_ready, cmd_valid, check_err, tx_done, tx_abort, link_abort;
    fslc_pkg::fslc_word_t cmd_word;
    fslc_pkg::fslc_word_t cmdq[$];
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_check = 0;
    int n_done = 0;
    int n_abort = 0;
    int n_link = 0;

    // Short reply window keeps the timeout retry cheap to reach
    fslc_link #(.REPLY_CYC(50)) i_fslc_link (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .framed_protocol_setting_i(framed), .handshake_en_i(hs_en), .clear_to_send_i(cts),
        .data_set_ready_i(dsr), .module_addr_i(8'h37), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
        .rx_ready_o(rx_ready), .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .resp_byte_i(resp_byte), .resp_last_i(resp_last), .resp_repeat_i(resp_rep), .resp_valid_i(resp_valid),
        .resp_ready_o(resp_ready), .cmd_word_o(cmd_word), .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready),
        .check_error_o(check_err), .tx_done_o(tx_done), .tx_abort_o(tx_abort), .link_abort_o(link_abort));
    fslc_host_model i_fslc_host_model (.ref_clk_i(ref_clk_i), .ready_i(rx_ready), .byte_o(rx_byte),
        .valid_o(rx_valid), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

    initial forever #50 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1) cmdq.push_back(cmd_word);
        if (check_err === 1'b1) n_check++;
        if (tx_done === 1'b1) n_done++;
        if (tx_abort === 1'b1) n_abort++;
        if (link_abort === 1'b1) n_link++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks made %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic get_tx(input logic [7:0] e, input string n);
        logic [7:0] got;
        int w;
        w = 0;
        got = 'x;
        while (i_fslc_host_model.txq.size() == 0 && w < 500) begin
            @(negedge ref_clk_i);
            w++;
        end
        if (i_fslc_host_model.txq.size() > 0) got = i_fslc_host_model.txq.pop_front();
        `CHK(n, e, got)
    endtask

    task automatic expect_frame(input logic [7:0] p[$]);
        logic [7:0] x;
        x = 8'h37 ^ fslc_pkg::CH_END;
        get_tx(fslc_pkg::CH_START, "frame start");
        get_tx(8'h37, "frame address");
        foreach (p[i]) begin
            get_tx(p[i], "frame payload");
            x ^= p[i];
        end
        get_tx(fslc_pkg::CH_END, "frame end");
        get_tx(x, "frame check");
    endtask

    task automatic send_resp(input logic [7:0] p[$], input logic rep);
        foreach (p[i]) begin
            @(negedge ref_clk_i);
            resp_valid = 1'b1;
            resp_byte = p[i];
            resp_last = (i == p.size() - 1);
            resp_rep = rep;
            while (resp_ready !== 1'b1) @(negedge ref_clk_i);
            @(posedge ref_clk_i);
        end
        @(negedge ref_clk_i);
        resp_valid = 1'b0;
        resp_byte = ~resp_byte;
    endtask

    task automatic t_handshake();
        hs_en = 1'b1;
        dsr = 1'b0;
        wait_cyc(3);
        `CHK("rx ready blocked", 1'b0, rx_ready)
        hs_en = 1'b0;
        wait_cyc(3);
        `CHK("rx ready free", 1'b1, rx_ready)
        dsr = 1'b1;
    endtask

    task automatic t_good_fill();
        logic [7:0] p[$];
        fslc_pkg::fslc_word_t w;
        for (int i = 0; i < 10; i++) p.push_back(8'hf0 + i[7:0]);
        i_fslc_host_model.slow = 1'b1;
        i_fslc_host_model.send_frame(p, 8'h00);
        get_tx(fslc_pkg::CH_ACK, "ack");
        wait_cyc(30);
        `CHK("fifo holding", 1'b1, cmd_valid)
        cmd_ready = 1'b1;
        wait_cyc(20);
        `CHK("words delivered", 10, cmdq.size())
        // Pop once into a local so a mismatch report does not pop again
        for (int i = 0; i < 10 && cmdq.size() > 0; i++) begin
            w = cmdq.pop_front();
            `CHK("word", {i == 9, p[i]}, w)
        end
        `CHK("no check error", 0, n_check)
    endtask

    task automatic t_bad_check();
        int b0, l0;
        b0 = n_check;
        l0 = n_link;
        // Check byte lands on 04 and must be taken as a check byte
        i_fslc_host_model.send_frame({8'h53, 8'h49}, 8'h2a);
        get_tx(fslc_pkg::CH_NAK, "nak");
        wait_cyc(10);
        `CHK("check error pulse", b0 + 1, n_check)
        `CHK("no abort on check", l0, n_link)
        `CHK("nothing delivered", 0, cmdq.size())
    endtask

    task automatic t_eot_mid();
        int l0;
        fslc_pkg::fslc_word_t w;
        l0 = n_link;
        i_fslc_host_model.put(fslc_pkg::CH_START);
        i_fslc_host_model.put(8'h37);
        i_fslc_host_model.reply(fslc_pkg::CH_EOT);
        wait_cyc(5);
        `CHK("link abort", l0 + 1, n_link)
        i_fslc_host_model.send_frame({8'h41}, 8'h00);
        get_tx(fslc_pkg::CH_ACK, "ack after abort");
        wait_cyc(10);
        `CHK("single word", 1, cmdq.size())
        w = (cmdq.size() > 0) ? cmdq.pop_front() : 'x;
        `CHK("word", 9'h141, w)
    endtask

    task automatic t_resp_retry();
        int a0;
        a0 = n_abort;
        send_resp({8'h53, 8'h44}, 1'b0);
        expect_frame({8'h53, 8'h44});
        i_fslc_host_model.reply(fslc_pkg::CH_NAK);
        expect_frame({8'h53, 8'h44});
        expect_frame({8'h53, 8'h44});
        i_fslc_host_model.reply(fslc_pkg::CH_NAK);
        get_tx(fslc_pkg::CH_EOT, "eot");
        wait_cyc(3);
        `CHK("abort pulse", a0 + 1, n_abort)
    endtask

    task automatic t_resp_ack();
        int d0;
        d0 = n_done;
        send_resp({8'h88}, 1'b0);
        expect_frame({8'h88});
        i_fslc_host_model.reply(fslc_pkg::CH_ACK);
        wait_cyc(60);
        `CHK("done pulse", d0 + 1, n_done)
        `CHK("no resend", 0, i_fslc_host_model.txq.size())
        send_resp({8'h57}, 1'b1);
        expect_frame({8'h57});
        send_resp({8'h58}, 1'b1);
        expect_frame({8'h58});
        wait_cyc(60);
        `CHK("repeat done", d0 + 3, n_done)
        `CHK("repeat no resend", 0, i_fslc_host_model.txq.size())
    endtask

    task automatic t_raw();
        fslc_pkg::fslc_word_t w;
        framed = 1'b0;
        i_fslc_host_model.reply(fslc_pkg::CH_START);
        wait_cyc(5);
        `CHK("raw word", 1, cmdq.size())
        w = (cmdq.size() > 0) ? cmdq.pop_front() : 'x;
        `CHK("raw data", 9'h102, w)
        `CHK("raw no ack", 0, i_fslc_host_model.txq.size())
        // Raw mode gates response intake on clear to send only with handshake on, so the pin shows once hs_en is set
        cts = 1'b0;
        wait_cyc(3);
        `CHK("cts ignored", 1'b1, resp_ready)
        hs_en = 1'b1;
        wait_cyc(3);
        `CHK("raw tx blocked", 1'b0, resp_ready)
        cts = 1'b1;
        send_resp({8'h41}, 1'b0);
        get_tx(8'h41, "raw tx");
        hs_en = 1'b0;
        framed = 1'b1;
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        wait_cyc(3);
        t_handshake();
        t_good_fill();
        t_bad_check();
        t_eot_mid();
        t_resp_retry();
        t_resp_ack();
        t_raw();
        print_verdict();
    end
endmodule
